// ==== hw/afc_ctrl.sv ====
`timescale 1ns/1ps
module afc_ctrl #(
  parameter int DATA_W     = 9,
  parameter int NDEV       = 1,
  parameter int FIFO_DEPTH = 4096
) (
  // clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RESETN,
  // apb slave
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [7:0]            PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  // buffer strobes and data
  output logic                       WRITE_STROBE_N,
  output logic                       READ_STROBE_N,
  output logic      [DATA_W-1:0]     WRITE_DATA_IN,
  input  wire logic [DATA_W-1:0]     READ_DATA_OUT,
  // buffer control
  output logic                       MASTER_CLEAR_N,
  output logic                       REPLAY_PULSE_N,
  output logic                       FIRST_LOAD_N,
  output logic                       CHAIN_IN_N,
  output logic                       CHAIN_IN_OE,
  // buffer flags, one per device
  input  wire logic [NDEV-1:0]       EMPTY_FLAG_N,
  input  wire logic [NDEV-1:0]       FULL_FLAG_N,
  input  wire logic [NDEV-1:0]       HALF_LEVEL_N
);

  localparam int WCNT_W = $clog2(FIFO_DEPTH) + 2;
  localparam int FLAG_W = 3 * NDEV;

  typedef enum logic [2:0] {
    S_IDLE, S_WR_LOW, S_RD_LOW, S_MC_LOW, S_RT_LOW, S_SETTLE
  } afc_state_e;

  afc_state_e                       state_reg;
  logic [afc_pkg::CNT_W-1:0]        cnt_reg;
  logic                             op_apb_reg;
  logic                             op_rd_reg;
  logic [DATA_W-1:0]                rdata_reg;
  logic [afc_pkg::CFG_W-1:0]        cfg_reg;
  logic [afc_pkg::STICKY_W-1:0]     sticky_reg;
  logic [WCNT_W-1:0]                wcount_reg;
  logic [FLAG_W-1:0]                flags_s;
  logic [DATA_W-1:0]                rd_data_s;
  logic                             empty_n_s, full_n_s, half_n_s;
  logic                             apb_pend, idle_take;
  logic                             is_cmd, is_wdata, is_rdata, is_status, is_cfg;
  logic                             req_wr, req_rd, req_mc, req_rt;
  logic                             rt_allowed;
  logic                             start_wr, start_rd, start_rt;
  logic                             done_imm, settle_end, apb_done;
  logic [afc_pkg::STICKY_W-1:0]     sticky_set;
  logic [afc_pkg::STICKY_W-1:0]     sticky_clr;
  logic [31:0]                      status_word;

  // flags and read data come from pins, so they cross three stages and a filtered output register
  afc_sync #(.W(FLAG_W), .RST_VAL({{NDEV{1'b1}}, {NDEV{1'b1}}, {NDEV{1'b0}}})) u_flag_sync (
    .clk   (CLK),
    .rst_n (RESETN),
    .d     ({HALF_LEVEL_N, FULL_FLAG_N, EMPTY_FLAG_N}),
    .q     (flags_s)
  );

  afc_sync #(.W(DATA_W), .RST_VAL('0)) u_data_sync (
    .clk   (CLK),
    .rst_n (RESETN),
    .d     (READ_DATA_OUT),
    .q     (rd_data_s)
  );

  // composite flags across a depth chain; half level from device 0
  assign empty_n_s = |flags_s[NDEV-1:0];
  assign full_n_s  = |flags_s[2*NDEV-1:NDEV];
  assign half_n_s  = flags_s[2*NDEV] | cfg_reg[afc_pkg::CFG_DEPTH];

  assign is_cmd    = (PADDR == afc_pkg::ADDR_CMD);
  assign is_wdata  = (PADDR == afc_pkg::ADDR_WDATA);
  assign is_rdata  = (PADDR == afc_pkg::ADDR_RDATA);
  assign is_status = (PADDR == afc_pkg::ADDR_STATUS);
  assign is_cfg    = (PADDR == afc_pkg::ADDR_CFG);

  // requests are only decided from idle, after the flags have settled
  assign apb_pend   = PSEL & PENABLE & ~PREADY;
  assign idle_take  = (state_reg == S_IDLE) & apb_pend;
  assign req_wr     = idle_take & PWRITE & is_wdata;
  assign req_rd     = idle_take & ~PWRITE & is_rdata;
  assign req_mc     = idle_take & PWRITE & is_cmd & PWDATA[afc_pkg::CMD_CLEAR];
  assign req_rt     = idle_take & PWRITE & is_cmd & PWDATA[afc_pkg::CMD_REPLAY] & ~PWDATA[afc_pkg::CMD_CLEAR];
  assign rt_allowed = ~cfg_reg[afc_pkg::CFG_DEPTH] & (wcount_reg <= WCNT_W'(FIFO_DEPTH));
  assign start_wr   = req_wr & full_n_s;
  assign start_rd   = req_rd & empty_n_s;
  assign start_rt   = req_rt & rt_allowed;
  assign done_imm   = idle_take & ~(start_wr | start_rd | req_mc | start_rt);
  assign settle_end = (state_reg == S_SETTLE) & (cnt_reg == '0);
  assign apb_done   = done_imm | (settle_end & op_apb_reg);

  assign sticky_set = {req_rt & ~rt_allowed, req_rd & ~empty_n_s, req_wr & ~full_n_s};
  assign sticky_clr = (done_imm & PWRITE & is_status) ?
                      PWDATA[afc_pkg::ST_STICKY +: afc_pkg::STICKY_W] : '0;

  always_comb begin
    status_word = '0;
    status_word[afc_pkg::ST_EMPTY] = ~empty_n_s;
    status_word[afc_pkg::ST_FULL]  = ~full_n_s;
    status_word[afc_pkg::ST_HALF]  = ~half_n_s;
    status_word[afc_pkg::ST_STICKY +: afc_pkg::STICKY_W] = sticky_reg;
    status_word[afc_pkg::ST_COUNT +: WCNT_W] = wcount_reg;
  end

  // strobe sequencer; reset begins with the power-up master clear
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg      <= S_MC_LOW;
      cnt_reg        <= afc_pkg::CNT_W'(afc_pkg::PULSE_CYC - 1);
      op_apb_reg     <= 1'b0;
      op_rd_reg      <= 1'b0;
      rdata_reg      <= '0;
      WRITE_STROBE_N <= 1'b1;
      READ_STROBE_N  <= 1'b1;
      WRITE_DATA_IN  <= '0;
      MASTER_CLEAR_N <= 1'b0;
      REPLAY_PULSE_N <= 1'b1;
    end else begin
      case (state_reg)
        S_IDLE: begin
          op_rd_reg <= start_rd;
          if (start_wr) begin
            WRITE_DATA_IN  <= PWDATA[DATA_W-1:0];
            WRITE_STROBE_N <= 1'b0;
            cnt_reg        <= afc_pkg::CNT_W'(afc_pkg::PULSE_CYC - 1);
            state_reg      <= S_WR_LOW;
            op_apb_reg     <= 1'b1;
          end else if (start_rd) begin
            READ_STROBE_N <= 1'b0;
            cnt_reg       <= afc_pkg::CNT_W'(afc_pkg::RD_LOW_CYC - 1);
            state_reg     <= S_RD_LOW;
            op_apb_reg    <= 1'b1;
          end else if (req_mc) begin
            MASTER_CLEAR_N <= 1'b0;
            cnt_reg        <= afc_pkg::CNT_W'(afc_pkg::PULSE_CYC - 1);
            state_reg      <= S_MC_LOW;
            op_apb_reg     <= 1'b1;
          end else if (start_rt) begin
            REPLAY_PULSE_N <= 1'b0;
            cnt_reg        <= afc_pkg::CNT_W'(afc_pkg::PULSE_CYC - 1);
            state_reg      <= S_RT_LOW;
            op_apb_reg     <= 1'b1;
          end
        end
        S_WR_LOW, S_RD_LOW, S_MC_LOW, S_RT_LOW: begin
          if (cnt_reg == '0) begin
            if (state_reg == S_RD_LOW) begin
              rdata_reg <= rd_data_s;
            end
            WRITE_STROBE_N <= 1'b1;
            READ_STROBE_N  <= 1'b1;
            MASTER_CLEAR_N <= 1'b1;
            REPLAY_PULSE_N <= 1'b1;
            cnt_reg        <= afc_pkg::CNT_W'(afc_pkg::SETTLE_CYC - 1);
            state_reg      <= S_SETTLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        S_SETTLE: begin
          // both strobes stay high: covers recovery and lets flags settle
          if (cnt_reg == '0) begin
            state_reg  <= S_IDLE;
            op_apb_reg <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // apb answer
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= '0;
    end else begin
      PREADY  <= apb_done;
      PSLVERR <= done_imm & ~(is_cmd | is_wdata | is_rdata | is_status | is_cfg);
      if (settle_end & op_apb_reg & op_rd_reg) begin
        PRDATA <= 32'(rdata_reg);
      end else if (done_imm & ~PWRITE) begin
        case (1'b1)
          is_status: PRDATA <= status_word;
          is_cfg:    PRDATA <= 32'(cfg_reg);
          default:   PRDATA <= '0;
        endcase
      end else begin
        PRDATA <= '0;
      end
    end
  end

  // refused requests; a new event beats a clear in the same cycle
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sticky_reg <= '0;
    end else begin
      sticky_reg <= (sticky_reg & ~sticky_clr) | sticky_set;
    end
  end

  // strap-like pins; a new config reaches the pins one cycle after the write, with no master clear
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_reg      <= afc_pkg::CFG_RST;
      FIRST_LOAD_N <= 1'b1;
      CHAIN_IN_N   <= 1'b0;
      CHAIN_IN_OE  <= 1'b1;
    end else begin
      if (done_imm & PWRITE & is_cfg) begin
        cfg_reg <= PWDATA[afc_pkg::CFG_W-1:0];
      end
      FIRST_LOAD_N <= ~cfg_reg[afc_pkg::CFG_FIRST];
      CHAIN_IN_N   <= 1'b0;
      CHAIN_IN_OE  <= ~cfg_reg[afc_pkg::CFG_DEPTH];
    end
  end

  // writes since the last master clear, saturating past the depth
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      wcount_reg <= '0;
    end else if (req_mc) begin
      wcount_reg <= '0;
    end else if (start_wr && wcount_reg <= WCNT_W'(FIFO_DEPTH)) begin
      wcount_reg <= wcount_reg + 1'b1;
    end
  end

  property p_mc_quiet;
    @(posedge CLK) disable iff (!RESETN)
    !MASTER_CLEAR_N |-> (WRITE_STROBE_N && READ_STROBE_N);
  endproperty
  a_mc_quiet: assert property (p_mc_quiet) else $error("strobe active during master clear");

  property p_rt_quiet;
    @(posedge CLK) disable iff (!RESETN)
    !REPLAY_PULSE_N |-> (WRITE_STROBE_N && READ_STROBE_N);
  endproperty
  a_rt_quiet: assert property (p_rt_quiet) else $error("strobe active during replay");

  property p_rt_recover;
    @(posedge CLK) disable iff (!RESETN)
    $rose(REPLAY_PULSE_N) |-> (WRITE_STROBE_N && READ_STROBE_N)[*6];
  endproperty
  a_rt_recover: assert property (p_rt_recover) else $error("strobe too soon after replay");

  property p_wr_gate;
    @(posedge CLK) disable iff (!RESETN)
    $fell(WRITE_STROBE_N) |-> $past(full_n_s);
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("write issued while full");

  property p_rd_gate;
    @(posedge CLK) disable iff (!RESETN)
    $fell(READ_STROBE_N) |-> $past(empty_n_s);
  endproperty
  a_rd_gate: assert property (p_rd_gate) else $error("read issued while empty");

  property p_rt_mode;
    @(posedge CLK) disable iff (!RESETN)
    $fell(REPLAY_PULSE_N) |-> $past(rt_allowed);
  endproperty
  a_rt_mode: assert property (p_rt_mode) else $error("replay in depth mode or past depth");

  property p_wr_width;
    @(posedge CLK) disable iff (!RESETN)
    $fell(WRITE_STROBE_N) |-> (!WRITE_STROBE_N)[*2] ##1 WRITE_STROBE_N;
  endproperty
  a_wr_width: assert property (p_wr_width) else $error("write pulse width wrong");

  property p_wr_hold;
    @(posedge CLK) disable iff (!RESETN)
    $rose(WRITE_STROBE_N) |-> $stable(WRITE_DATA_IN) ##1 $stable(WRITE_DATA_IN);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write data moved at strobe rise");

  property p_rd_settle;
    @(posedge CLK) disable iff (!RESETN)
    $rose(READ_STROBE_N) |-> (READ_STROBE_N && WRITE_STROBE_N)[*6];
  endproperty
  a_rd_settle: assert property (p_rd_settle) else $error("next strobe before flags settle");

  property p_rd_width;
    @(posedge CLK) disable iff (!RESETN)
    $fell(READ_STROBE_N) |-> (!READ_STROBE_N)[*5] ##1 READ_STROBE_N;
  endproperty
  a_rd_width: assert property (p_rd_width) else $error("read pulse width wrong");

endmodule

// ==== hw/afc_pkg.sv ====
package afc_pkg;

  // clock and timing
  localparam int CLK_MHZ       = 50;
  localparam int T_PULSE_NS    = 30;
  localparam int T_RECOV_NS    = 10;
  localparam int T_ACCESS_NS   = 10;
  localparam int T_FLAG_NS     = 40;
  localparam int SYNC_LAT      = 4;

  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max_int(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  localparam int PULSE_CYC  = ns_to_cyc(T_PULSE_NS);
  localparam int RECOV_CYC  = ns_to_cyc(T_RECOV_NS);
  localparam int ACCESS_CYC = ns_to_cyc(T_ACCESS_NS);
  localparam int FLAG_CYC   = ns_to_cyc(T_FLAG_NS);
  // read stays low until the data has crossed the synchroniser
  localparam int RD_LOW_CYC = max_int(PULSE_CYC, ACCESS_CYC + SYNC_LAT);
  localparam int SETTLE_CYC = max_int(RECOV_CYC, FLAG_CYC + SYNC_LAT);
  localparam int CNT_W      = 4;

  // register map
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  ADDR_CMD    = 8'h00;
  localparam logic [7:0]  ADDR_WDATA  = 8'h04;
  localparam logic [7:0]  ADDR_RDATA  = 8'h08;
  localparam logic [7:0]  ADDR_STATUS = 8'h0C;
  localparam logic [7:0]  ADDR_CFG    = 8'h10;

  // command bits
  localparam int CMD_CLEAR  = 0;
  localparam int CMD_REPLAY = 1;

  // config bits
  localparam int          CFG_DEPTH = 0;
  localparam int          CFG_FIRST = 1;
  localparam int          CFG_W     = 2;
  localparam logic [1:0]  CFG_RST   = 2'h0;

  // status bits
  localparam int ST_EMPTY   = 0;
  localparam int ST_FULL    = 1;
  localparam int ST_HALF    = 2;
  localparam int ST_WR_REF  = 3;
  localparam int ST_RD_REF  = 4;
  localparam int ST_RT_REF  = 5;
  localparam int ST_STICKY  = 3;
  localparam int STICKY_W   = 3;
  localparam int ST_COUNT   = 16;

endpackage

// ==== hw/afc_sync.sv ====
`timescale 1ns/1ps
module afc_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a bit moves only once two stages agree, so a one-cycle glitch never counts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST_VAL;
    end else begin
      q <= (s2_reg & ~(s2_reg ^ s3_reg)) | (q & (s2_reg ^ s3_reg));
    end
  end

endmodule

// ==== verif/afc_dev_model.sv ====
`timescale 1ns/1ps
module afc_dev_model #(
  parameter int DEPTH = 256
) (
  // strobes and data
  input  wire logic       wr_strobe_n,
  input  wire logic       rd_strobe_n,
  input  wire logic [8:0] wr_data,
  output wire logic [8:0] rd_data,
  // control
  input  wire logic       master_clear_n,
  input  wire logic       replay_pulse_n,
  // flags
  output logic            empty_flag_n,
  output logic            full_flag_n,
  output logic            half_level_n
);
  logic [8:0] mem [DEPTH];
  logic [8:0] q_reg = 9'h0A5;
  logic       drive = 1'b0;
  int         wp;
  int         rp;
  // a floating bus shows the inverse, so a late capture cannot pass by luck
  assign rd_data = drive ? q_reg : ~q_reg;
  always_comb begin
    empty_flag_n = (wp != rp);
    full_flag_n  = ((wp - rp) != DEPTH);
    half_level_n = !((wp - rp) > DEPTH / 2);
  end
  always @(negedge master_clear_n) begin
    wp = 0;
    rp = 0;
    drive = 1'b0;
  end
  always @(posedge wr_strobe_n) begin
    if (master_clear_n && (wp - rp) < DEPTH) begin
      mem[wp % DEPTH] = wr_data;
      wp = wp + 1;
    end
  end
  always @(negedge rd_strobe_n) begin
    if (master_clear_n && wp != rp) begin
      q_reg = mem[rp % DEPTH];
      drive = 1'b1;
      rp = rp + 1;
    end
  end
  always @(posedge rd_strobe_n) drive = 1'b0;
  // rewind assumes no more than DEPTH writes since the clear
  always @(negedge replay_pulse_n) begin
    if (master_clear_n) rp = 0;
  end
endmodule

// ==== verif/async_fifo_read_retransmit_expansion_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module async_fifo_read_retransmit_expansion_tb_top;
  logic        CLK = 1'b0;
  logic        RESETN = 1'b0;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        WRITE_STROBE_N;
  logic        READ_STROBE_N;
  logic [8:0]  WRITE_DATA_IN;
  wire  [8:0]  READ_DATA_OUT;
  logic        MASTER_CLEAR_N;
  logic        REPLAY_PULSE_N;
  logic        FIRST_LOAD_N;
  logic        CHAIN_IN_N;
  logic        CHAIN_IN_OE;
  logic [0:0]  EMPTY_FLAG_N;
  logic [0:0]  FULL_FLAG_N;
  logic [0:0]  HALF_LEVEL_N;
  int          mismatches = 0;
  int          check_count = 0;
  int          rt_pulses = 0;
  localparam int DEPTH = 256;
  logic        last_err;

  always #10 CLK = ~CLK;

  afc_ctrl #(.DATA_W(9), .NDEV(1), .FIFO_DEPTH(DEPTH)) i_afc_ctrl (
    .CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .WRITE_STROBE_N(WRITE_STROBE_N), .READ_STROBE_N(READ_STROBE_N), .WRITE_DATA_IN(WRITE_DATA_IN),
    .READ_DATA_OUT(READ_DATA_OUT), .MASTER_CLEAR_N(MASTER_CLEAR_N), .REPLAY_PULSE_N(REPLAY_PULSE_N),
    .FIRST_LOAD_N(FIRST_LOAD_N), .CHAIN_IN_N(CHAIN_IN_N), .CHAIN_IN_OE(CHAIN_IN_OE),
    .EMPTY_FLAG_N(EMPTY_FLAG_N), .FULL_FLAG_N(FULL_FLAG_N), .HALF_LEVEL_N(HALF_LEVEL_N));

  afc_dev_model #(.DEPTH(DEPTH)) i_afc_dev_model (
    .wr_strobe_n(WRITE_STROBE_N), .rd_strobe_n(READ_STROBE_N), .wr_data(WRITE_DATA_IN),
    .rd_data(READ_DATA_OUT), .master_clear_n(MASTER_CLEAR_N), .replay_pulse_n(REPLAY_PULSE_N),
    .empty_flag_n(EMPTY_FLAG_N[0]), .full_flag_n(FULL_FLAG_N[0]), .half_level_n(HALF_LEVEL_N[0]));

  always @(negedge REPLAY_PULSE_N) rt_pulses++;
  always @(posedge CLK) begin
    if (RESETN && !REPLAY_PULSE_N) `CHK({WRITE_STROBE_N, READ_STROBE_N}, 2'h3)
  end

  task automatic complete_run();
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // waits for the slave with no assumed latency; only the watchdog ends it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    last_err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    apb(1'b1, a, d, dummy);
  endtask

  task automatic rd_word(input logic [8:0] exp);
    logic [31:0] v;
    apb(1'b0, afc_pkg::ADDR_RDATA, 32'h0, v);
    `CHK(v, {23'h0, exp})
  endtask

  task automatic st(input logic [5:0] exp);
    logic [31:0] v;
    apb(1'b0, afc_pkg::ADDR_STATUS, 32'h0, v);
    `CHK(v[5:0], exp)
  endtask

  task automatic clear_all();
    w(afc_pkg::ADDR_STATUS, 32'h38);
    w(afc_pkg::ADDR_CMD, 32'h1);
  endtask

  task automatic t_reset_state();
    `CHK({FIRST_LOAD_N, CHAIN_IN_N, CHAIN_IN_OE}, 3'h5)
    st(6'h01);
  endtask

  task automatic t_empty_read();
    rd_word(9'h000);
    st(6'h11);
    rd_word(9'h000);
    clear_all();
    st(6'h01);
  endtask

  task automatic t_order();
    for (int i = 0; i < 3; i++) w(afc_pkg::ADDR_WDATA, 32'h1C0 + i);
    st(6'h00);
    for (int i = 0; i < 3; i++) rd_word(9'h1C0 + i);
    st(6'h01);
  endtask

  task automatic t_fill();
    int p;
    clear_all();
    for (int i = 0; i < DEPTH; i++) begin
      w(afc_pkg::ADDR_WDATA, 32'h0F0 + i);
      st({3'h0, (i + 1 > DEPTH / 2), (i == DEPTH - 1), 1'b0});
    end
    w(afc_pkg::ADDR_WDATA, 32'h1FF);
    st(6'h0E);
    // half level is still low at the pin here, so the depth-mode mask is really exercised
    w(afc_pkg::ADDR_CFG, 32'h1);
    st(6'h0A);
    w(afc_pkg::ADDR_CFG, 32'h0);
    for (int i = 0; i < DEPTH; i++) rd_word(9'h0F0 + i);
    for (int i = 0; i < 3; i++) w(afc_pkg::ADDR_WDATA, 32'h055 + i);
    for (int i = 0; i < 3; i++) rd_word(9'h055 + i);
    // more writes than the depth since the clear: replay must be refused
    p = rt_pulses;
    w(afc_pkg::ADDR_CMD, 32'h2);
    `CHK(rt_pulses, p)
    st(6'h29);
  endtask

  task automatic t_replay();
    int p;
    clear_all();
    for (int i = 0; i < 4; i++) w(afc_pkg::ADDR_WDATA, 32'h0A0 + i);
    rd_word(9'h0A0);
    rd_word(9'h0A1);
    p = rt_pulses;
    w(afc_pkg::ADDR_CMD, 32'h2);
    `CHK(rt_pulses, p + 1)
    for (int i = 4; i < 6; i++) w(afc_pkg::ADDR_WDATA, 32'h0A0 + i);
    st(6'h00);
    for (int i = 0; i < 6; i++) rd_word(9'h0A0 + i);
    st(6'h01);
    w(afc_pkg::ADDR_CMD, 32'h2);
    for (int i = 0; i < 6; i++) rd_word(9'h0A0 + i);
  endtask

  task automatic t_depth_mode();
    int p;
    w(afc_pkg::ADDR_CFG, 32'h1);
    w(afc_pkg::ADDR_CMD, 32'h1);
    `CHK(CHAIN_IN_OE, 1'b0)
    p = rt_pulses;
    w(afc_pkg::ADDR_CMD, 32'h2);
    `CHK(rt_pulses, p)
    st(6'h21);
    w(afc_pkg::ADDR_CFG, 32'h2);
    w(afc_pkg::ADDR_CMD, 32'h1);
    `CHK({FIRST_LOAD_N, CHAIN_IN_OE}, 2'h1)
    w(afc_pkg::ADDR_CFG, 32'h0);
    clear_all();
    st(6'h01);
  endtask

  task automatic t_unmapped();
    logic [31:0] v;
    apb(1'b0, 8'h20, 32'h0, v);
    `CHK({last_err, v}, 33'h100000000)
    apb(1'b1, 8'h24, 32'h1, v);
    `CHK(last_err, 1'b1)
  endtask

  initial begin
    repeat (10) @(posedge CLK);
    RESETN <= 1'b1;
    t_reset_state();
    t_empty_read();
    t_order();
    t_fill();
    t_replay();
    t_depth_mode();
    t_unmapped();
    complete_run();
  end

  // roughly eight and a half thousand cycles of traffic expected; generous margin
  initial begin
    repeat (40000) @(posedge CLK);
    mismatches++;
    complete_run();
  end
endmodule
